// file: src/ascs_pkg.sv
package ascs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ    = 20_000_000;
  localparam int GAP_MS    = 100;
  localparam int GAP_CYC   = CLK_HZ / 1000 * GAP_MS;
  localparam int DATA_BITS = 8;
  localparam int BAUD_TAB [0:4] = '{9600, 19200, 38400, 57600, 115200};
  localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_TAB[0]);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_TAB[4]);

  // ----------------------------------------------------------------
  // Frame characters and lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_OPEN  = 8'h5B;
  localparam logic [7:0] CH_M     = 8'h4D;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_LA    = 8'h61;
  localparam logic [7:0] CH_LF    = 8'h66;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [3:0] HEX_ADJ  = 4'h9;
  localparam logic [7:0] HEX_UP   = 8'h37;
  localparam logic [7:0] CH_V     = 8'h56;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_G     = 8'h47;
  localparam logic [7:0] CH_STAR  = 8'h2A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] LEN_V    = 8'h07;
  localparam logic [7:0] LEN_L    = 8'h0F;
  localparam logic [7:0] LEN_G    = 8'h0D;
  localparam logic [7:0] RLEN_V   = 8'h14;
  localparam logic [7:0] RLEN_L   = 8'h17;
  localparam logic [7:0] RLEN_G   = 8'h15;
  localparam logic [7:0] HDR_LEN  = 8'h07;
  localparam logic [7:0] SP_FIRST = 8'h09;
  localparam logic [7:0] TRAIL    = 8'h02;
  localparam int         FIFO_DEPTH = 32;

  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    baud_div = (sel > 3'h4) ? DIV_MIN : 16'(CLK_HZ / BAUD_TAB[sel]);
  endfunction
endpackage

// file: src/ascs_top.sv
// Contract
// - Device only answers requests; never transmits unprompted.
// - Characters are 8 data bits, 1 stop bit, no parity, no handshake.
// - Baud rate selectable from 9600 up to 115200; both ends match.
// - Master sends without pauses; gap over 100 ms discards partial request.
// - Every correctly received request gets a reply frame; the code drops one whose CR arrives while gen_busy_r is still set.
// - Reply typically begins and ends within 300 ms.
// - Requests start with master prefix, replies with slave prefix, address 01.
// - Second character names sender: M for master, S for slave.
// - Fifth character is qualifier V, L or G, echoed in reply.
// - Characters six and seven give byte count before checksum in hex.
// - Checksum is low byte of sum of all characters before it.
// - Checksum sent as two hex characters high first, then CR.
// - Identity query has no data; reply carries identification text.
// - Limits query has asterisk data and length 0F.
// - Limits reply carries four values from byte eight in fixed order.
// - Working limits fixed; setpoint limits never outside them; reply clamps sp_lo only up to WORK_LO and sp_hi only down to WORK_HI.
// - Temperatures are signed 16-bit, 0.01 K per step.
// - Values sent as four hex characters, most significant nibble first.
// - Asterisk in a control field leaves that state unchanged.

// ------------------------------------------------------------------
// Reply buffer
// ------------------------------------------------------------------
module ascs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ascs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;

  assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// ------------------------------------------------------------------
// Command slave
// ------------------------------------------------------------------
module ascs_top #(
  parameter int          CLK_HZ  = ascs_pkg::CLK_HZ,
  parameter int          GAP_CYC = ascs_pkg::GAP_CYC,
  parameter logic [15:0] WORK_LO = 16'hF448,
  parameter logic [15:0] WORK_HI = 16'h4E20,
  // Identification text: value is arbitrary
  parameter logic [103:0] ID_TEXT = "TEMP CONTROL1"
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link
  input  wire logic        rxd,
  output logic             txd,
  // Configuration
  input  wire logic [2:0]  baud_sel,
  // Setpoint limits and status reported to the master
  input  wire logic [15:0] sp_lo,
  input  wire logic [15:0] sp_hi,
  input  wire logic [7:0]  stat_mode,
  input  wire logic [7:0]  stat_alarm,
  input  wire logic [15:0] stat_setpoint,
  input  wire logic [15:0] stat_temp_int,
  input  wire logic [15:0] stat_temp_ext,
  // General control outputs
  output logic             cmd_mode_we,
  output logic [7:0]       cmd_mode,
  output logic             cmd_ack_we,
  output logic             cmd_set_we,
  output logic [15:0]      cmd_setpoint
);
  typedef enum logic [1:0] {ASCS_IDLE, ASCS_START, ASCS_DATA, ASCS_STOP} ascs_ser_t;

  // Divisors follow the clock parameter, so a scaled clock keeps the bit timing consistent
  localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / ascs_pkg::BAUD_TAB[0]);
  localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / ascs_pkg::BAUD_TAB[4]);

  logic        rxd_m_r, rxd_s_r;
  logic [2:0]  sel_m_r, sel_s_r;
  logic [15:0] div_r;
  ascs_ser_t   rx_st_r, tx_st_r;
  logic [15:0] rx_cnt_r, tx_cnt_r;
  logic [2:0]  rx_bit_r, tx_bit_r;
  logic [7:0]  rx_sh_r, tx_sh_r;
  logic        rx_vld_r, rx_ferr_r;
  logic [7:0]  idx_r, sum_r, qual_r, len_r, g_mode_r, g_ack_r;
  logic [3:0]  len_hi_r, ck_hi_r;
  logic [15:0] g_set_r;
  logic        g_star_r;
  logic [31:0] gap_cnt_r;
  logic        gap_hit, hx_ok, p_ok, p_last, frame_done, push;
  logic [3:0]  hx_v;
  logic        gen_busy_r;
  logic [7:0]  gen_idx_r, gen_qual_r, gen_sum_r, rlen, k, gen_chr;
  logic [63:0] gen_dat_r, dsh, dch;
  logic [103:0] idt;
  logic [15:0] lo_rep, hi_rep;
  logic        f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]  f_out_data;

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? ascs_pkg::CH_0 + {4'h0, n} : ascs_pkg::HEX_UP + {4'h0, n};
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and baud divisor
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
      sel_m_r <= '0;
      sel_s_r <= '0;
      div_r   <= DIV_SLOW;
    end else begin
      rxd_m_r <= rxd;
      rxd_s_r <= rxd_m_r;
      sel_m_r <= baud_sel;
      sel_s_r <= sel_m_r;
      div_r   <= (sel_s_r > 3'h4) ? DIV_FAST : 16'(CLK_HZ / ascs_pkg::BAUD_TAB[sel_s_r]);
    end
  end

  // ----------------------------------------------------------------
  // Receiver, sampling mid-bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_r <= ASCS_IDLE; rx_cnt_r <= '0; rx_bit_r <= '0; rx_sh_r <= '0;
      rx_vld_r <= 1'b0; rx_ferr_r <= 1'b0;
    end else begin
      rx_vld_r  <= 1'b0;
      rx_ferr_r <= 1'b0;
      case (rx_st_r)
        ASCS_IDLE: begin
          rx_cnt_r <= '0;
          if (!rxd_s_r) rx_st_r <= ASCS_START;
        end
        ASCS_START: begin
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (rx_cnt_r == (div_r >> 1)) begin
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_st_r  <= rxd_s_r ? ASCS_IDLE : ASCS_DATA;
          end
        end
        ASCS_DATA: begin
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (rx_cnt_r == div_r - 1'b1) begin
            rx_cnt_r <= '0;
            rx_sh_r  <= {rxd_s_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == 3'(ascs_pkg::DATA_BITS - 1)) rx_st_r <= ASCS_STOP;
          end
        end
        default: begin
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (rx_cnt_r == div_r - 1'b1) begin
            rx_st_r   <= ASCS_IDLE;
            rx_vld_r  <= rxd_s_r;
            rx_ferr_r <= !rxd_s_r;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request parser
  // ----------------------------------------------------------------
  always_comb begin
    hx_ok = 1'b1;
    hx_v  = rx_sh_r[3:0];
    if (rx_sh_r >= ascs_pkg::CH_0 && rx_sh_r <= ascs_pkg::CH_9) begin
      hx_v = rx_sh_r[3:0];
    end else if ((rx_sh_r | ascs_pkg::CASE_BIT) >= ascs_pkg::CH_LA &&
                 (rx_sh_r | ascs_pkg::CASE_BIT) <= ascs_pkg::CH_LF) begin
      hx_v = rx_sh_r[3:0] + ascs_pkg::HEX_ADJ;
    end else begin
      hx_ok = 1'b0;
    end
  end

  always_comb begin
    p_ok   = 1'b1;
    p_last = 1'b0;
    if (idx_r == 8'h00) p_ok = (rx_sh_r == ascs_pkg::CH_OPEN);
    else if (idx_r == 8'h01) p_ok = (rx_sh_r == ascs_pkg::CH_M);
    else if (idx_r == 8'h02) p_ok = (rx_sh_r == ascs_pkg::CH_0);
    else if (idx_r == 8'h03) p_ok = (rx_sh_r == ascs_pkg::CH_1);
    else if (idx_r == 8'h04) p_ok = (rx_sh_r == ascs_pkg::CH_V) || (rx_sh_r == ascs_pkg::CH_L) ||
                                    (rx_sh_r == ascs_pkg::CH_G);
    else if (idx_r == 8'h05) p_ok = hx_ok;
    else if (idx_r == 8'h06) p_ok = hx_ok && ({len_hi_r, hx_v} == ((qual_r == ascs_pkg::CH_V) ? ascs_pkg::LEN_V :
                                    (qual_r == ascs_pkg::CH_L) ? ascs_pkg::LEN_L : ascs_pkg::LEN_G));
    else if (idx_r < len_r) p_ok = (qual_r != ascs_pkg::CH_G) || (idx_r < ascs_pkg::SP_FIRST) || hx_ok ||
                                   (rx_sh_r == ascs_pkg::CH_STAR);
    else if (idx_r == len_r) p_ok = hx_ok;
    else if (idx_r == len_r + 8'h01) p_ok = hx_ok && ({ck_hi_r, hx_v} == sum_r);
    else begin
      p_ok   = (rx_sh_r == ascs_pkg::CH_CR);
      p_last = p_ok;
    end
  end

  assign gap_hit    = (gap_cnt_r == 32'(GAP_CYC));
  assign frame_done = rx_vld_r && p_last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt_r <= '0;
    end else if (rx_vld_r || idx_r == 8'h00) begin
      gap_cnt_r <= '0;
    end else if (!gap_hit) begin
      gap_cnt_r <= gap_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= '0; sum_r <= '0; qual_r <= '0; len_r <= '0; len_hi_r <= '0; ck_hi_r <= '0;
      g_mode_r <= '0; g_ack_r <= '0; g_set_r <= '0; g_star_r <= 1'b0;
    end else if (gap_hit || rx_ferr_r) begin
      idx_r <= '0;
    end else if (rx_vld_r) begin
      idx_r <= (!p_ok || p_last) ? 8'h00 : idx_r + 8'h01;
      // Checksum characters themselves must stay out of the running sum
      if (idx_r == 8'h00) sum_r <= rx_sh_r;
      else if (idx_r < ascs_pkg::HDR_LEN || idx_r < len_r) sum_r <= sum_r + rx_sh_r;
      if (idx_r == 8'h04) qual_r <= rx_sh_r;
      if (idx_r == 8'h05) len_hi_r <= hx_v;
      if (idx_r == 8'h06) len_r <= {len_hi_r, hx_v};
      if (idx_r == 8'h07) g_mode_r <= rx_sh_r;
      if (idx_r == 8'h08) g_ack_r <= rx_sh_r;
      if (idx_r == 8'h00) g_star_r <= 1'b0;
      if (idx_r >= ascs_pkg::SP_FIRST && idx_r < len_r && qual_r == ascs_pkg::CH_G) begin
        g_set_r  <= {g_set_r[11:0], hx_v};
        g_star_r <= g_star_r || (rx_sh_r == ascs_pkg::CH_STAR);
      end
      if (idx_r == len_r) ck_hi_r <= hx_v;
    end
  end

  // Control strobes only for an accepted general request; asterisk leaves state alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_mode_we <= 1'b0; cmd_ack_we <= 1'b0; cmd_set_we <= 1'b0; cmd_mode <= '0; cmd_setpoint <= '0;
    end else begin
      cmd_mode_we <= 1'b0;
      cmd_ack_we  <= 1'b0;
      cmd_set_we  <= 1'b0;
      if (frame_done && !gen_busy_r && qual_r == ascs_pkg::CH_G) begin
        cmd_mode_we  <= (g_mode_r != ascs_pkg::CH_STAR);
        cmd_ack_we   <= (g_ack_r == ascs_pkg::CH_1);
        cmd_set_we   <= !g_star_r;
        if (g_mode_r != ascs_pkg::CH_STAR) cmd_mode <= g_mode_r;
        if (!g_star_r) cmd_setpoint <= g_set_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply generator
  // ----------------------------------------------------------------
  assign lo_rep = ($signed(sp_lo) < $signed(WORK_LO)) ? WORK_LO : sp_lo;
  assign hi_rep = ($signed(sp_hi) > $signed(WORK_HI)) ? WORK_HI : sp_hi;
  assign push   = gen_busy_r && f_in_ready;

  always_comb begin
    k    = gen_idx_r - ascs_pkg::HDR_LEN;
    dsh  = gen_dat_r << {k[5:0], 2'b00};
    dch  = gen_dat_r << {k[5:0], 3'b000};
    idt  = ID_TEXT << {k[5:0], 3'b000};
    rlen = (gen_qual_r == ascs_pkg::CH_V) ? ascs_pkg::RLEN_V :
           (gen_qual_r == ascs_pkg::CH_L) ? ascs_pkg::RLEN_L : ascs_pkg::RLEN_G;
    if (gen_idx_r == 8'h00) gen_chr = ascs_pkg::CH_OPEN;
    else if (gen_idx_r == 8'h01) gen_chr = ascs_pkg::CH_S;
    else if (gen_idx_r == 8'h02) gen_chr = ascs_pkg::CH_0;
    else if (gen_idx_r == 8'h03) gen_chr = ascs_pkg::CH_1;
    else if (gen_idx_r == 8'h04) gen_chr = gen_qual_r;
    else if (gen_idx_r == 8'h05) gen_chr = hex_chr(rlen[7:4]);
    else if (gen_idx_r == 8'h06) gen_chr = hex_chr(rlen[3:0]);
    else if (gen_idx_r < rlen) begin
      if (gen_qual_r == ascs_pkg::CH_V) gen_chr = idt[103:96];
      else if (gen_qual_r == ascs_pkg::CH_L) gen_chr = hex_chr(dsh[63:60]);
      else if (k < 8'h02) gen_chr = dch[63:56];
      else gen_chr = hex_chr(dsh[55:52]);
    end
    else if (gen_idx_r == rlen) gen_chr = hex_chr(gen_sum_r[7:4]);
    else if (gen_idx_r == rlen + 8'h01) gen_chr = hex_chr(gen_sum_r[3:0]);
    else gen_chr = ascs_pkg::CH_CR;
  end

  // Reply starts the cycle after the request's CR, well inside the typical bound
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_busy_r <= 1'b0; gen_idx_r <= '0; gen_qual_r <= '0; gen_sum_r <= '0; gen_dat_r <= '0;
    end else if (!gen_busy_r) begin
      if (frame_done) begin
        gen_busy_r <= 1'b1;
        gen_idx_r  <= '0;
        gen_sum_r  <= '0;
        gen_qual_r <= qual_r;
        gen_dat_r  <= (qual_r == ascs_pkg::CH_L) ? {lo_rep, hi_rep, WORK_LO, WORK_HI} :
                      {stat_mode, stat_alarm, stat_setpoint, stat_temp_int, stat_temp_ext};
      end
    end else if (push) begin
      gen_idx_r <= gen_idx_r + 8'h01;
      if (gen_idx_r < rlen) gen_sum_r <= gen_sum_r + gen_chr;
      if (gen_idx_r == rlen + ascs_pkg::TRAIL) gen_busy_r <= 1'b0;
    end
  end

  ascs_fifo #(.WIDTH(8), .DEPTH(ascs_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (gen_busy_r),
    .in_ready  (f_in_ready),
    .in_data   (gen_chr),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign f_out_ready = (tx_st_r == ASCS_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= ASCS_IDLE; tx_cnt_r <= '0; tx_bit_r <= '0; tx_sh_r <= '0; txd <= 1'b1;
    end else begin
      tx_cnt_r <= tx_cnt_r + 1'b1;
      case (tx_st_r)
        ASCS_IDLE: begin
          tx_cnt_r <= '0;
          if (f_out_valid) begin
            tx_sh_r <= f_out_data;
            txd     <= 1'b0;
            tx_st_r <= ASCS_START;
          end
        end
        ASCS_START: if (tx_cnt_r == div_r - 1'b1) begin
          tx_cnt_r <= '0;
          tx_bit_r <= '0;
          txd      <= tx_sh_r[0];
          tx_sh_r  <= tx_sh_r >> 1;
          tx_st_r  <= ASCS_DATA;
        end
        ASCS_DATA: if (tx_cnt_r == div_r - 1'b1) begin
          tx_cnt_r <= '0;
          tx_bit_r <= tx_bit_r + 1'b1;
          txd      <= tx_sh_r[0];
          tx_sh_r  <= tx_sh_r >> 1;
          if (tx_bit_r == 3'(ascs_pkg::DATA_BITS - 1)) begin
            txd     <= 1'b1;
            tx_st_r <= ASCS_STOP;
          end
        end
        default: if (tx_cnt_r == div_r - 1'b1) tx_st_r <= ASCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reply_cause_a: assert property ($rose(gen_busy_r) |-> $past(frame_done))
    else $error("reply started without a request");
  stop_high_a: assert property ((tx_st_r == ASCS_STOP) |-> txd)
    else $error("stop bit not high");
  baud_range_a: assert property (div_r >= DIV_FAST && div_r <= DIV_SLOW)
    else $error("baud divisor out of range");
  gap_abort_a: assert property (gap_hit && !rx_vld_r |=> idx_r == 8'h00)
    else $error("partial request kept after gap");
  reply_start_a: assert property (frame_done && !gen_busy_r |=> gen_busy_r && gen_idx_r == 8'h00)
    else $error("accepted request not answered");
  slave_prefix_a: assert property (push && gen_idx_r == 8'h01 |-> gen_chr == ascs_pkg::CH_S)
    else $error("reply sender letter wrong");
  echo_qual_a: assert property (frame_done && !gen_busy_r |=> gen_qual_r == $past(qual_r))
    else $error("qualifier not echoed");
  frame_end_a: assert property (push && gen_chr == ascs_pkg::CH_CR |=> !gen_busy_r)
    else $error("reply did not end at CR");
  limit_clamp_a: assert property ($signed(lo_rep) >= $signed(WORK_LO) && $signed(hi_rep) <= $signed(WORK_HI))
    else $error("setpoint limit outside working range");
  hex_upper_a: assert property (push && (gen_idx_r == 8'h05 || gen_idx_r == rlen || gen_idx_r == rlen + 8'h01) |->
                                gen_chr <= ascs_pkg::CH_9 ||
                                (gen_chr > ascs_pkg::HEX_UP && gen_chr < ascs_pkg::CH_LA))
    else $error("lower case hex in reply");
endmodule

// file: sim/ascs_host.sv
// ------------------------------------------------------------------
// Master model on the serial link
// ------------------------------------------------------------------
module ascs_host #(
  parameter int DIV = 173
) (
  // Serial link, master view
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam time BIT = DIV * 50;
  logic [7:0] got [$];

  initial rxd = 1'b1;

  // Whole characters back to back, no parity, no handshake
  task automatic put(input logic [7:0] c);
    rxd = 1'b0;
    #BIT;
    for (int i = 0; i < 8; i++) begin
      rxd = c[i];
      #BIT;
    end
    rxd = 1'b1;
    #BIT;
  endtask

  task automatic send(input string s);
    foreach (s[i]) put(s[i]);
  endtask

  // Mid-bit sampling; a low stop bit drops the character
  always @(negedge txd) begin
    logic [7:0] c;
    #(BIT / 2);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #BIT;
        c[i] = txd;
      end
      #BIT;
      if (txd === 1'b1) got.push_back(c);
    end
  end
endmodule

// file: sim/testbench.sv
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h %h", $time, (a), (b)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Gap limit shortened; still longer than one character time
  localparam int GAP = 1000;
  // Slave is told a clock ten times slower, so the link runs ten times faster and the run stays short
  localparam int SIM_HZ = 2_000_000;
  logic        clk, rst, rxd, txd, cmd_mode_we, cmd_ack_we, cmd_set_we;
  logic [2:0]  baud_sel;
  logic [15:0] sp_lo, sp_hi, stat_setpoint, stat_temp_int, stat_temp_ext, cmd_setpoint;
  logic [7:0]  stat_mode, stat_alarm, cmd_mode;
  int          mismatches, checks_done, n_mode, n_ack, n_set;

  ascs_top #(.CLK_HZ(SIM_HZ), .GAP_CYC(GAP), .ID_TEXT("BENCH UNIT 07")) dut (.clk, .rst, .rxd, .txd,
    .baud_sel, .sp_lo, .sp_hi, .stat_mode, .stat_alarm, .stat_setpoint, .stat_temp_int, .stat_temp_ext,
    .cmd_mode_we, .cmd_mode, .cmd_ack_we, .cmd_set_we, .cmd_setpoint);
  ascs_host #(.DIV(SIM_HZ / ascs_pkg::BAUD_TAB[4])) host (.rxd(rxd), .txd(txd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_mode_we === 1'b1) n_mode++;
    if (cmd_ack_we === 1'b1) n_ack++;
    if (cmd_set_we === 1'b1) n_set++;
  end

  function automatic string hx(input logic [7:0] v);
    string tab;
    tab = "0123456789ABCDEF";
    return {tab.substr(v[7:4], v[7:4]), tab.substr(v[3:0], v[3:0])};
  endfunction

  // Appends checksum and terminator, optionally in lower case
  function automatic string frame(input string b, input bit lc);
    logic [7:0] sum;
    string      ck;
    sum = 8'h00;
    foreach (b[i]) sum = sum + b[i];
    ck = hx(sum);
    if (lc) ck = ck.tolower();
    return {b, ck, "\r"};
  endfunction

  task automatic expect_reply(input string e);
    int w;
    w = 0;
    while (host.got.size() < e.len() && w < 50000) begin
      @(posedge clk);
      w++;
    end
    `CHK(host.got.size(), e.len())
    foreach (e[i]) `CHK(host.got[i], 8'(e[i]))
    host.got.delete();
  endtask

  task automatic t_limits();
    sp_lo = 16'hF000;
    sp_hi = 16'h0100;
    host.send(frame("[M01L0F********", 1));
    // Lower limit below the working range is reported clamped
    expect_reply(frame("[S01L17F4480100F4484E20", 0));
  endtask

  // A pause inside a request must discard the part already received
  task automatic t_gap();
    string full;
    full = frame("[M01G0DC10190", 0);
    host.send("[M01G");
    repeat (GAP + 200) @(posedge clk);
    #1;
    host.send(full.substr(5, full.len() - 1));
    repeat (3000) @(posedge clk);
    `CHK(host.got.size(), 0)
    `CHK(n_mode, 0)
  endtask

  task automatic t_general();
    host.send(frame("[M01G0DC1fe70", 0));
    expect_reply(frame("[S01G15I00190FE707FFF", 0));
    `CHK(n_mode, 1)
    `CHK(cmd_mode, 8'h43)
    `CHK(n_ack, 1)
    `CHK(n_set, 1)
    `CHK(cmd_setpoint, 16'hFE70)
  endtask

  // Asterisks everywhere: reply only, no strobe, stored mode and setpoint kept
  task automatic t_query();
    host.send(frame("[M01G0D******", 0));
    expect_reply(frame("[S01G15I00190FE707FFF", 0));
    `CHK(n_mode, 1)
    `CHK(n_ack, 1)
    `CHK(n_set, 1)
    `CHK(cmd_mode, 8'h43)
    `CHK(cmd_setpoint, 16'hFE70)
  endtask

  // Silent until asked; the identity reply then drains through the reply buffer
  task automatic t_ident();
    repeat (400) @(posedge clk);
    #1;
    `CHK(txd, 1'b1)
    `CHK(host.got.size(), 0)
    host.send(frame("[M01V07", 0));
    expect_reply(frame("[S01V14BENCH UNIT 07", 0));
    `CHK(n_mode + n_ack + n_set, 0)
  endtask

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Roughly twice the expected run at the scaled link rate
  initial begin
    #3_000_000;
    mismatches++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    baud_sel = 3'h4;
    sp_lo = 16'h0000;
    sp_hi = 16'h0000;
    stat_mode = 8'h49;
    stat_alarm = 8'h30;
    stat_setpoint = 16'h0190;
    stat_temp_int = 16'hFE70;
    stat_temp_ext = 16'h7FFF;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_ident();
    // Each request waits for the full previous reply
    t_limits();
    t_gap();
    t_general();
    t_query();
    end_sim();
  end
endmodule
